// ### deser_strap_config_capture.sv
// Power-up strap capture, register override and shared-pin control
// Summary of operation
// - Sample all straps at power-up and fix configuration from them
// - An unconnected strap reads low; a pull-up makes it high
// - Strap pins are inputs during power-up and outputs afterwards
// - Mode 00 disables the control filter, 01 enables it
// - Modes 10 and 11 select the two older partner kinds
// - Low-frequency spread select only matters with spread enabled
// - Clock slew select: 1 increased, 0 normal
// - Data slew select: 1 increased, 0 normal
// - Hold-low strap keeps outputs low until software release
// - Without hold-low, outputs toggle as soon as lock rises
// - Sleep select with power-down sets outputs while powered down
// - Strobe-edge select 1 gives rising-edge strobed outputs
// - Four-bit equalization setting from straps or register
// - Three-bit oscillator select from straps or register
// - Four-bit spread range select from straps or register
// - Two-bit bit-mapping field, normally 00
// - Power-down input low resets all control registers
// - With filter on, HS and DE pulses under three clocks are dropped; VS is not filtered
// - Lock is high when PLL locked and outputs active
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module deser_strap_config_capture #(
  parameter int SETTLE_CYC = strap_cfg_pkg::STRAP_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        power_down_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Receive core side
  input  wire logic [23:0] rx_data_i,
  input  wire logic        rx_hs_i,
  input  wire logic        rx_vs_i,
  input  wire logic        rx_de_i,
  input  wire logic        pll_locked_i,
  input  wire logic        bist_pass_i,
  // Shared strap and pixel pins
  input  wire logic [23:0] pix_i,
  output var  logic [23:0] pix_o,
  output var  logic [23:0] pix_oe_n_o,
  input  wire logic        pass_i,
  output var  logic        pass_o,
  output var  logic        pass_oe_n_o,
  // Video control and link status
  output var  logic        hs_o,
  output var  logic        vs_o,
  output var  logic        de_o,
  output var  logic        ctl_oe_n_o,
  output var  logic        lock_o,
  // Effective configuration
  output var  logic [1:0]  mode_o,
  output var  logic        filter_en_o,
  output var  logic        legacy_partner_o,
  output var  logic        spread_en_o,
  output var  logic        spread_low_freq_sel_o,
  output var  logic        clock_slew_sel_o,
  output var  logic        data_slew_sel_o,
  output var  logic        strobe_edge_sel_o,
  output var  logic        sleep_state_sel_o,
  output var  logic [3:0]  rx_equalization_o,
  output var  logic [2:0]  oscillator_sel_o,
  output var  logic [3:0]  spread_range_sel_o,
  output var  logic [1:0]  bit_map_sel_o
);
  localparam int W = strap_cfg_pkg::CFG_W;

  // Pins are released one edge into sampling, so one cycle is too few
  if (SETTLE_CYC < 2 || SETTLE_CYC > 255) begin : g_bad_settle
    $error("SETTLE_CYC must be 2 to 255");
  end
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  strap_cfg_pkg::cap_state_e state;
  logic [7:0]   settle_cnt;
  logic [W-1:0] strap_q;
  logic [1:0]   ctl;
  logic [W-1:0] ovr_mask;
  logic [W-1:0] ovr_val;
  logic [W-1:0] cfg;
  logic         ctl_rst;
  logic         capture;
  logic         hold;
  logic         req;
  logic         hs_f;
  logic         de_f;
  logic [31:0]  next_ctl;
  logic [31:0]  next_mask;
  logic [31:0]  next_val;

  cfg_select_if #(.W(W)) sel_if ();

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [W-1:0] strap_map(input logic [23:0] p,
                                             input logic        pass);
    logic [W-1:0] m;
    m = strap_cfg_pkg::CFG_RST;
    m[strap_cfg_pkg::F_MODE + 1] = p[strap_cfg_pkg::PIN_B6];
    m[strap_cfg_pkg::F_MODE]     = p[strap_cfg_pkg::PIN_B7];
    m[strap_cfg_pkg::F_LF]       = p[strap_cfg_pkg::PIN_B4];
    m[strap_cfg_pkg::F_CSLEW]    = p[strap_cfg_pkg::PIN_B5];
    m[strap_cfg_pkg::F_DSLEW]    = p[strap_cfg_pkg::PIN_B3];
    m[strap_cfg_pkg::F_HOLD]     = pass;
    m[strap_cfg_pkg::F_SLEEP]    = p[strap_cfg_pkg::PIN_B2];
    m[strap_cfg_pkg::F_STROBE]   = p[strap_cfg_pkg::PIN_B1];
    m[strap_cfg_pkg::F_EQL +: strap_cfg_pkg::W_EQL] =
      p[strap_cfg_pkg::PIN_EQL_LSB +: strap_cfg_pkg::W_EQL];
    m[strap_cfg_pkg::F_OSC +: strap_cfg_pkg::W_OSC] =
      p[strap_cfg_pkg::PIN_OSC_LSB +: strap_cfg_pkg::W_OSC];
    m[strap_cfg_pkg::F_SPR +: strap_cfg_pkg::W_SPR] =
      p[strap_cfg_pkg::PIN_SPR_LSB +: strap_cfg_pkg::W_SPR];
    m[strap_cfg_pkg::F_MAP +: strap_cfg_pkg::W_MAP] =
      p[strap_cfg_pkg::PIN_MAP_LSB +: strap_cfg_pkg::W_MAP];
    return m;
  endfunction : strap_map

  assign ctl_rst = rst_i || !power_down_n_i;
  assign capture = state == strap_cfg_pkg::ST_SAMPLE && power_down_n_i &&
                   settle_cnt == SETTLE_LAST;
  assign cfg     = sel_if.value;
  // hold until release, ahead of the selector flop
  assign hold    = (ovr_mask[strap_cfg_pkg::F_HOLD] ?
                    ovr_val[strap_cfg_pkg::F_HOLD] :
                    strap_q[strap_cfg_pkg::F_HOLD]) &&
                   !ctl[strap_cfg_pkg::CTL_RELEASE];
  assign req     = wb_cyc_i && wb_stb_i;

  // Power-up sequencing; rst_i counts as a power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state      <= strap_cfg_pkg::ST_SAMPLE;
      settle_cnt <= 8'h00;
    end else begin
      case (state)
        strap_cfg_pkg::ST_DOWN: begin
          settle_cnt <= 8'h00;
          if (power_down_n_i) begin
            state <= strap_cfg_pkg::ST_SAMPLE;
          end
        end
        strap_cfg_pkg::ST_SAMPLE: begin
          if (!power_down_n_i) begin
            state <= strap_cfg_pkg::ST_DOWN;
          end else if (capture) begin
            state <= strap_cfg_pkg::ST_RUN;
          end else begin
            settle_cnt <= settle_cnt + 8'h01;
          end
        end
        strap_cfg_pkg::ST_RUN: begin
          if (!power_down_n_i) begin
            state <= strap_cfg_pkg::ST_DOWN;
          end
        end
        default: begin
          state <= strap_cfg_pkg::ST_DOWN;
        end
      endcase
    end
  end

  // released pins read low unless pulled up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= strap_cfg_pkg::CFG_RST;
    end else if (capture) begin
      strap_q <= strap_map(pix_i, pass_i);
    end
  end

  assign sel_if.strap   = strap_q;
  assign sel_if.reg_val = ovr_val;
  assign sel_if.mask    = ovr_mask;

  cfg_override_sel #(.W(W)) u_sel (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sel   (sel_if.chooser)
  );

  assign mode_o = cfg[strap_cfg_pkg::F_MODE +: strap_cfg_pkg::W_MODE];
  assign clock_slew_sel_o = cfg[strap_cfg_pkg::F_CSLEW];
  assign data_slew_sel_o = cfg[strap_cfg_pkg::F_DSLEW];
  assign strobe_edge_sel_o = cfg[strap_cfg_pkg::F_STROBE];
  assign sleep_state_sel_o = cfg[strap_cfg_pkg::F_SLEEP];
  assign rx_equalization_o = cfg[strap_cfg_pkg::F_EQL +: strap_cfg_pkg::W_EQL];
  assign oscillator_sel_o = cfg[strap_cfg_pkg::F_OSC +: strap_cfg_pkg::W_OSC];
  assign spread_range_sel_o =
    cfg[strap_cfg_pkg::F_SPR +: strap_cfg_pkg::W_SPR];
  assign bit_map_sel_o = cfg[strap_cfg_pkg::F_MAP +: strap_cfg_pkg::W_MAP];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_en_o           <= 1'b0;
      legacy_partner_o      <= 1'b0;
      spread_en_o           <= 1'b0;
      spread_low_freq_sel_o <= 1'b0;
    end else begin
      filter_en_o           <= mode_o == strap_cfg_pkg::MODE_FILTER_ON;
      legacy_partner_o      <= mode_o[1];
      spread_en_o           <= ctl[strap_cfg_pkg::CTL_SPREAD_EN];
      spread_low_freq_sel_o <= ctl[strap_cfg_pkg::CTL_SPREAD_EN] &&
                               cfg[strap_cfg_pkg::F_LF];
    end
  end

  ctrl_pulse_filter #(.MIN_CYC(strap_cfg_pkg::CTRL_MIN_PCLK)) u_hs_flt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (filter_en_o),
    .level_i  (rx_hs_i),
    .level_o  (hs_f)
  );

  ctrl_pulse_filter #(.MIN_CYC(strap_cfg_pkg::CTRL_MIN_PCLK)) u_de_flt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (filter_en_o),
    .level_i  (rx_de_i),
    .level_o  (de_f)
  );

  // Pin drive; outputs start released so straps can be read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_o       <= 24'h000000;
      pix_oe_n_o  <= 24'hffffff;
      hs_o        <= 1'b0;
      vs_o        <= 1'b0;
      de_o        <= 1'b0;
      ctl_oe_n_o  <= 1'b1;
      pass_o      <= 1'b0;
      pass_oe_n_o <= 1'b1;
    end else if (state == strap_cfg_pkg::ST_RUN && pll_locked_i &&
                 power_down_n_i) begin
      pass_o      <= bist_pass_i;
      pass_oe_n_o <= 1'b0;
      ctl_oe_n_o  <= 1'b0;
      pix_oe_n_o  <= 24'h000000;
      if (hold) begin
        pix_o <= 24'h000000;
        hs_o  <= 1'b0;
        vs_o  <= 1'b0;
        de_o  <= 1'b0;
      end else begin
        pix_o <= rx_data_i;
        hs_o  <= hs_f;
        vs_o  <= rx_vs_i;
        de_o  <= de_f;
      end
    end else if (state == strap_cfg_pkg::ST_SAMPLE && power_down_n_i) begin
      pix_oe_n_o  <= 24'hffffff;
      pass_oe_n_o <= 1'b1;
      ctl_oe_n_o  <= 1'b1;
    end else begin
      // sleep state: 1 drives low, 0 releases
      pix_o       <= 24'h000000;
      hs_o        <= 1'b0;
      vs_o        <= 1'b0;
      de_o        <= 1'b0;
      pass_o      <= 1'b0;
      pix_oe_n_o  <= {24{!sleep_state_sel_o}};
      ctl_oe_n_o  <= !sleep_state_sel_o;
      pass_oe_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_o <= 1'b0;
    end else begin
      lock_o <= state == strap_cfg_pkg::ST_RUN && pll_locked_i &&
                power_down_n_i;
    end
  end

  // Wishbone: ack one cycle after request, write lands on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req && !wb_ack_o) begin
      case (wb_adr_i)
        strap_cfg_pkg::ADR_CONTROL:   wb_dat_o <= 32'(ctl);
        strap_cfg_pkg::ADR_OVR_MASK:  wb_dat_o <= 32'(ovr_mask);
        strap_cfg_pkg::ADR_OVR_VAL:   wb_dat_o <= 32'(ovr_val);
        strap_cfg_pkg::ADR_STRAPPED:  wb_dat_o <= 32'(strap_q);
        strap_cfg_pkg::ADR_EFFECTIVE: wb_dat_o <= 32'(cfg);
        strap_cfg_pkg::ADR_STATUS: begin
          wb_dat_o <= 32'h00000000;
          wb_dat_o[strap_cfg_pkg::STA_LOCK]   <= lock_o;
          wb_dat_o[strap_cfg_pkg::STA_HOLD]   <= hold;
          wb_dat_o[strap_cfg_pkg::STA_RUN]    <=
            state == strap_cfg_pkg::ST_RUN;
          wb_dat_o[strap_cfg_pkg::STA_SAMPLE] <=
            state == strap_cfg_pkg::ST_SAMPLE;
        end
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  always_comb begin
    next_ctl  = merge(32'(ctl), wb_dat_i, wb_sel_i);
    next_mask = merge(32'(ovr_mask), wb_dat_i, wb_sel_i);
    next_val  = merge(32'(ovr_val), wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      ctl      <= strap_cfg_pkg::CONTROL_RST;
      ovr_mask <= strap_cfg_pkg::CFG_RST;
      ovr_val  <= strap_cfg_pkg::CFG_RST;
    end else if (req && wb_ack_o && wb_we_i) begin
      case (wb_adr_i)
        strap_cfg_pkg::ADR_CONTROL:  ctl      <= next_ctl[1:0];
        strap_cfg_pkg::ADR_OVR_MASK: ovr_mask <= next_mask[W-1:0];
        strap_cfg_pkg::ADR_OVR_VAL:  ovr_val  <= next_val[W-1:0];
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  strap_capture_a: assert property (
    capture |=> strap_q == $past(strap_map(pix_i, pass_i)))
    else $error("strap capture mismatch");
  pins_released_a: assert property (
    state == strap_cfg_pkg::ST_SAMPLE && power_down_n_i |=>
      pix_oe_n_o == 24'hffffff && pass_oe_n_o)
    else $error("strap pins driven during sampling");
  filter_mode_a: assert property (
    mode_o == strap_cfg_pkg::MODE_FILTER_OFF |=> !filter_en_o)
    else $error("filter enabled in mode 00");
  legacy_sel_a: assert property (
    mode_o[1] |=> legacy_partner_o && !filter_en_o)
    else $error("older partner mode not selected");
  spread_gate_a: assert property (
    !spread_en_o |-> !spread_low_freq_sel_o)
    else $error("low frequency spread without spread enabled");
  hold_low_a: assert property (
    state == strap_cfg_pkg::ST_RUN && pll_locked_i && power_down_n_i &&
      hold |=> pix_o == 24'h000000 && pix_oe_n_o == 24'h000000 && lock_o)
    else $error("outputs not held low");
  normal_out_a: assert property (
    state == strap_cfg_pkg::ST_RUN && pll_locked_i && power_down_n_i &&
      !hold |=> pix_o == $past(rx_data_i) && lock_o)
    else $error("outputs not following data after lock");
  sleep_state_a: assert property (
    state == strap_cfg_pkg::ST_DOWN |=>
      pix_oe_n_o == {24{!$past(sleep_state_sel_o)}} && pix_o == 24'h000000)
    else $error("sleep state outputs wrong");
  pd_reset_a: assert property (
    !power_down_n_i |=> ctl == 2'h0 && ovr_mask == '0 && ovr_val == '0)
    else $error("control registers survive power-down");
  lock_drop_a: assert property (
    !pll_locked_i || state != strap_cfg_pkg::ST_RUN |=> !lock_o)
    else $error("lock high while not locked");
  strap_hold_a: assert property (
    state == strap_cfg_pkg::ST_RUN ##1 state == strap_cfg_pkg::ST_RUN |->
      $stable(strap_q))
    else $error("strap values changed while running");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  capture_c: cover property (capture ##1 state == strap_cfg_pkg::ST_RUN);
  release_c: cover property (hold ##[1:50] !hold);
  filter_c:  cover property (filter_en_o && lock_o);
  down_c:    cover property (lock_o ##1 !power_down_n_i);
endmodule : deser_strap_config_capture
`default_nettype wire

// ### strap_cfg_pkg.sv
// Constants shared by the strap configuration capture block
package strap_cfg_pkg;

  // Timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STRAP_SETTLE_NS  = 100;
  localparam int STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CTRL_MIN_PCLK    = 3;

  // Packed configuration word layout
  localparam int CFG_W    = 21;
  localparam int F_MODE   = 0;
  localparam int F_LF     = 2;
  localparam int F_CSLEW  = 3;
  localparam int F_DSLEW  = 4;
  localparam int F_HOLD   = 5;
  localparam int F_SLEEP  = 6;
  localparam int F_STROBE = 7;
  localparam int F_EQL    = 8;
  localparam int F_OSC    = 12;
  localparam int F_SPR    = 15;
  localparam int F_MAP    = 19;
  localparam int W_MODE   = 2;
  localparam int W_EQL    = 4;
  localparam int W_OSC    = 3;
  localparam int W_SPR    = 4;
  localparam int W_MAP    = 2;

  // Strap positions on the shared pixel pins (red 23:16, green 15:8, blue 7:0)
  localparam int PIN_B1      = 1;
  localparam int PIN_B2      = 2;
  localparam int PIN_B3      = 3;
  localparam int PIN_B4      = 4;
  localparam int PIN_B5      = 5;
  localparam int PIN_B6      = 6;
  localparam int PIN_B7      = 7;
  localparam int PIN_OSC_LSB = 8;
  localparam int PIN_EQL_LSB = 12;
  localparam int PIN_MAP_LSB = 16;
  localparam int PIN_SPR_LSB = 19;

  // Mode and bit-map encodings
  localparam logic [1:0] MODE_FILTER_OFF = 2'h0;
  localparam logic [1:0] MODE_FILTER_ON  = 2'h1;
  localparam logic [1:0] MAP_NORMAL      = 2'h0;

  // Register byte offsets
  localparam logic [7:0] ADR_CONTROL   = 8'h00;
  localparam logic [7:0] ADR_OVR_MASK  = 8'h04;
  localparam logic [7:0] ADR_OVR_VAL   = 8'h08;
  localparam logic [7:0] ADR_STRAPPED  = 8'h0c;
  localparam logic [7:0] ADR_EFFECTIVE = 8'h10;
  localparam logic [7:0] ADR_STATUS    = 8'h14;

  // Control and status bits
  localparam int CTL_RELEASE   = 0;
  localparam int CTL_SPREAD_EN = 1;
  localparam int STA_LOCK      = 0;
  localparam int STA_HOLD      = 1;
  localparam int STA_RUN       = 2;
  localparam int STA_SAMPLE    = 3;

  // Reset values
  localparam logic [1:0]       CONTROL_RST = 2'h0;
  localparam logic [CFG_W-1:0] CFG_RST     = 21'h000000;

  typedef enum logic [2:0] {
    ST_DOWN   = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_RUN    = 3'h4
  } cap_state_e;

endpackage : strap_cfg_pkg

// ### cfg_select_if.sv
// Carrier between the capture logic and the override selector
`timescale 1ns/100ps
`default_nettype none
interface cfg_select_if #(parameter int W = 21);
  logic [W-1:0] strap;
  logic [W-1:0] reg_val;
  logic [W-1:0] mask;
  logic [W-1:0] value;
  modport owner   (output strap, output reg_val, output mask, input value);
  modport chooser (input strap, input reg_val, input mask, output value);
endinterface : cfg_select_if
`default_nettype wire

// ### cfg_override_sel.sv
// Per-bit choice between strapped and register-written settings
`timescale 1ns/100ps
`default_nettype none
module cfg_override_sel #(
  parameter int W = 21
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Selection carrier
  cfg_select_if.chooser      sel
);
  if (W < 1) begin : g_bad_w
    $error("cfg_override_sel: W must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel.value <= '0;
    end else begin
      sel.value <= (sel.mask & sel.reg_val) | (~sel.mask & sel.strap);
    end
  end
endmodule : cfg_override_sel
`default_nettype wire

// ### ctrl_pulse_filter.sv
// Drops video control pulses shorter than a minimum length
`timescale 1ns/100ps
`default_nettype none
module ctrl_pulse_filter #(
  parameter int MIN_CYC = 3
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control level
  input  wire logic enable_i,
  input  wire logic level_i,
  output var  logic level_o
);
  if (MIN_CYC < 1 || MIN_CYC > 15) begin : g_bad_min
    $error("ctrl_pulse_filter: MIN_CYC must be 1 to 15");
  end

  localparam logic [3:0] MIN_LEN = 4'(MIN_CYC);

  logic       last;
  logic [3:0] run_len;
  logic [3:0] next_run;

  always_comb begin
    if (level_i != last) begin
      next_run = 4'h1;
    end else if (run_len < MIN_LEN) begin
      next_run = run_len + 4'h1;
    end else begin
      next_run = run_len;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last    <= 1'b0;
      run_len <= 4'h0;
    end else begin
      last    <= level_i;
      run_len <= next_run;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= 1'b0;
    end else if (!enable_i || next_run >= MIN_LEN) begin
      level_o <= level_i;
    end
  end

  pulse_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(enable_i) && $changed(level_o) |->
      $past(level_i, 1) == level_o && $past(level_i, 2) == level_o &&
      $past(level_i, 3) == level_o)
    else $error("control pulse forwarded before minimum length");
endmodule : ctrl_pulse_filter
`default_nettype wire

// ### strap_board.sv
// Board strap resistors on the shared pixel and pass pins
`timescale 1ns/100ps
`default_nettype none
module strap_board (
  // Resistor choice, 1 = pull-up
  input  wire logic [23:0] pull_up_i,
  input  wire logic        pass_up_i,
  // Device side of the pins
  input  wire logic [23:0] dev_pix_i,
  input  wire logic [23:0] dev_oe_n_i,
  input  wire logic        dev_pass_i,
  input  wire logic        dev_pass_oe_n_i,
  output var  logic [23:0] pix_o,
  output var  logic        pass_o
);
  // released pin rests on its resistor
  always_comb begin
    for (int b = 0; b < 24; b++) begin
      pix_o[b] = dev_oe_n_i[b] ? pull_up_i[b] : dev_pix_i[b];
    end
    pass_o = dev_pass_oe_n_i ? pass_up_i : dev_pass_i;
  end
endmodule : strap_board
`default_nettype wire

// ### deser_strap_config_capture_tb.sv
// Self-checking bench for the strap configuration capture block
`timescale 1ns/100ps
`default_nettype none
module deser_strap_config_capture_tb;
  typedef struct {logic [23:0] pins; logic [20:0] eff;} row_s;
  logic        clk_i, rst_i, power_down_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, mismatches, tests_run, seen;
  logic        wb_ack_o, rx_hs_i, rx_vs_i, rx_de_i, pll_locked_i, bist_pass_i;
  logic [23:0] rx_data_i, pix_i, pix_o, pix_oe_n_o, pull_up;
  logic        pass_i, pass_o, pass_oe_n_o, pass_up, hs_o, lock_o;
  logic        filter_en_o, legacy_partner_o, spread_low_freq_sel_o;
  logic [1:0]  mode_o;
  logic        vs_o, de_o, ctl_oe_n_o, spread_en_o, cs, ds, sb, sl;
  logic [3:0]  rxeq, sprd;
  logic [2:0]  oscs;
  logic [1:0]  mp;
  // Straps beside expected effective word, low-freq bit masked
  row_s rows [4] = '{'{24'h005040, 21'h000502}, '{24'h0307a0, 21'h187009},
    '{24'h000000, 21'h000000}, '{24'h7800de, 21'h0780d3}};

  deser_strap_config_capture #(.SETTLE_CYC(2)) deser_strap_config_capture_i (
    .clk_i, .rst_i, .power_down_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_data_i,
    .rx_hs_i, .rx_vs_i, .rx_de_i, .pll_locked_i, .bist_pass_i, .pix_i,
    .pix_o, .pix_oe_n_o, .pass_i, .pass_o, .pass_oe_n_o, .hs_o, .vs_o,
    .de_o, .ctl_oe_n_o, .lock_o, .mode_o, .filter_en_o,
    .legacy_partner_o, .spread_en_o, .spread_low_freq_sel_o,
    .clock_slew_sel_o(cs), .data_slew_sel_o(ds), .strobe_edge_sel_o(sb),
    .sleep_state_sel_o(sl), .rx_equalization_o(rxeq),
    .oscillator_sel_o(oscs), .spread_range_sel_o(sprd), .bit_map_sel_o(mp));
  strap_board strap_board_i (.pull_up_i(pull_up), .pass_up_i(pass_up),
    .dev_pix_i(pix_o), .dev_oe_n_i(pix_oe_n_o), .dev_pass_i(pass_o),
    .dev_pass_oe_n_i(pass_oe_n_o), .pix_o(pix_i), .pass_o(pass_i));

  task automatic close_out;
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    // Idle edge first keeps cycles apart
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic power_cycle;
    power_down_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    power_down_n_i <= 1'b1;
    for (int i = 0; i < 100 && lock_o !== 1'b1; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
  endtask : power_cycle

  task automatic pulse(input int n, output logic [31:0] hi);
    hi = 0;
    rx_hs_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rx_hs_i <= 1'b0;
    repeat (10) begin
      @(posedge clk_i);
      hi += (hs_o === 1'b1);
    end
  endtask : pulse

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    close_out();
  end

  initial begin
    rst_i = 1; power_down_n_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0;
    wb_adr_i = 0; wb_sel_i = 4'hf; wb_dat_i = 0; rx_hs_i = 0; rx_vs_i = 0;
    rx_de_i = 0; pll_locked_i = 1; bist_pass_i = 1; rx_data_i = 24'ha5c3e1;
    pull_up = 0; pass_up = 0; mismatches = 0; tests_run = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      pull_up <= rows[r].pins;
      power_cycle();
      wb(1'b0, 8'h10, 32'h0, q);
      chk(q & 32'h1ffffb, {11'h0, rows[r].eff});
      chk({mode_o, filter_en_o, legacy_partner_o}, {rows[r].eff[1:0],
          rows[r].eff[1:0] == 2'h1, rows[r].eff[1]});
      chk(spread_low_freq_sel_o, 0);
      chk(pix_o, rx_data_i);
      chk(lock_o, 1);
      chk({pass_oe_n_o, pass_o}, 2'b01);
      chk({mp, sprd, oscs, rxeq}, rows[r].eff[20:8]);
      chk({sb, sl, ds, cs}, {rows[r].eff[7:6], rows[r].eff[4:3]});
    end
    wb(1'b1, 8'h00, 32'h2, q);
    repeat (2) @(posedge clk_i);
    chk({spread_en_o, spread_low_freq_sel_o}, 2'b11);
    power_down_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({lock_o, ctl_oe_n_o, pix_oe_n_o | pix_o}, 0);
    wb(1'b0, 8'h00, 32'h0, q);
    chk(q, 0);
    pull_up <= 24'h0;
    pass_up <= 1'b1;
    power_cycle();
    chk(pix_o, 0);
    wb(1'b1, 8'h00, 32'h1, q);
    repeat (2) @(posedge clk_i);
    chk(pix_o, rx_data_i);
    rx_vs_i <= 1'b1;
    rx_de_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({vs_o, de_o, ctl_oe_n_o}, 3'b110);
    wb(1'b1, 8'h04, 32'h3, q);
    wb(1'b1, 8'h08, 32'h1, q);
    // Value register, then selector flop, then filter flag
    repeat (3) @(posedge clk_i);
    chk(filter_en_o, 1);
    pulse(2, seen);
    chk(seen, 0);
    pulse(4, seen);
    chk(seen != 0, 1);
    // Mid-run reset releases every pin again
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({lock_o, pix_oe_n_o, filter_en_o}, {1'b0, 24'hffffff, 1'b0});
    rst_i <= 1'b0;
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 0);
    close_out();
  end
endmodule : deser_strap_config_capture_tb
`default_nettype wire
